//--- logic/fsp_cfg.svh
// Register offsets, field positions, reset values and timing of the serial port.
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
`define FSP_A_BUF  4'h0
`define FSP_A_IER  4'h1
`define FSP_A_FCR  4'h2
`define FSP_A_LCR  4'h3
`define FSP_A_MCR  4'h4
`define FSP_A_LSR  4'h5
`define FSP_A_THR  4'h6
`define FSP_A_RXO  4'h7
`define FSP_A_TXO  4'h8
`define FSP_A_MUL  4'h9
`define FSP_A_DIV  4'ha
`define FSP_A_DMA  4'hb
`define FSP_A_OSC  4'hc
`define FSP_LCR_STB  2
`define FSP_LCR_PEN  3
`define FSP_LCR_EPS  4
`define FSP_LCR_DIVISOR_LATCH_ACCESS 7
`define FSP_MCR_RTS  1
`define FSP_MCR_AFE  5
`define FSP_FCR_EN   0
`define FSP_FCR_RXR  1
`define FSP_FCR_TXR  2
`define FSP_DMA_ACT  0
`define FSP_DMA_DIR  1
`define FSP_RST_MUL  32'h02a30000
`define FSP_RST_DIV  32'h02625a00
`define FSP_RST_DLL  8'h18
`define FSP_RST_LCR  8'h03
`define FSP_RST_THR  7'h30
`define FSP_CLK_NS   25
`define FSP_TRAIL_BITS 40
`endif

//--- logic/fsp_pkg.sv
// Types shared by the serial port design.
package fsp_pkg;
  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_START = 3'b001,
    T_DATA  = 3'b010,
    T_PAR   = 3'b011,
    T_STOP  = 3'b100
  } fsp_tx_st_t;
  typedef enum logic [2:0] {
    R_IDLE  = 3'b000,
    R_START = 3'b001,
    R_DATA  = 3'b010,
    R_PAR   = 3'b011,
    R_STOP  = 3'b100
  } fsp_rx_st_t;
endpackage

//--- logic/fsp_uart.sv
// Fast serial port: transmitter, receiver, FIFOs, rate synth, autoflow.
// Overview of operation
// - Frames are 7 to 12 bit periods depending on size, parity, stop.
// - A frame starts with the line falling from idle high to low.
// - Five to eight data bits follow, least significant bit first.
// - Optional parity bit: even or odd over the data bits.
// - Stop period of one, one and a half or two bits at one.
// - Separate transmit and receive FIFOs of 64 characters each.
// - Baud logic runs on the system clock, the source of the base.
// - Divisor is high byte in bits 15..8, low byte in bits 7..0.
// - Base frequency is system clock times multiplier over divisor.
// - The 3686400 setting uses thirteen base periods per bit.
// - All other rates use sixteen base periods per bit.
// - Bases 47923200 and 44236800 Hz with the divisors give the rates.
// - Receive DMA channel is direction 1, started after programming.
// - Transmit DMA channel is direction 0, started after programming.
// - Leftover receive bytes below trigger are still drained by DMA.
// - Enable bits 7 and 4..0 cleared with FIFOs on means polled mode.
// - Data ready is set while any received byte remains.
// - Transmit request when data needed; empty flag when all is empty.
// - With control bit 5 set, a byte starts only while clear-to-send is low; running ones end.
// - Control bits 1 and 5 give full autoflow, bit 5 alone half.
// - Full autoflow drops request at the threshold, restores below.
//
// Decided for this implementation: the register addresses and the plain strobed port.
module fsp_uart
  import fsp_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        port1_serial_in_i,
  input  wire logic        port1_cts_in_n_i,
  output logic             port1_serial_out_o,
  output logic             port1_rts_out_n_o,
  output logic             dma_rx_req_o,
  output logic             dma_tx_req_o
);
`include "fsp_cfg.svh"

  function automatic logic [7:0] fsp_mask(input logic [1:0] w);
    fsp_mask = 8'hff >> (2'd3 - w);
  endfunction

  logic [7:0]  dll, divisor_high_byte, ier, lcr, modem_control_register;
  logic        fifo_en, os13, oe, pe, fe;
  logic [AW:0] thr;
  logic [31:0] mult, ddiv, acc;
  logic [1:0]  dma;
  logic [15:0] dcnt;
  logic        rx_m, rx_s, cts_m, cts_s;

  // Register port decode.
  logic divisor_latch_access, wr_buf, rd_buf, rd_lsr, wr_fcr;
  assign divisor_latch_access   = lcr[`FSP_LCR_DIVISOR_LATCH_ACCESS];
  assign wr_buf = reg_wr_i && reg_addr_i == `FSP_A_BUF && !divisor_latch_access;
  assign rd_buf = reg_rd_i && reg_addr_i == `FSP_A_BUF && !divisor_latch_access;
  assign rd_lsr = reg_rd_i && reg_addr_i == `FSP_A_LSR;
  assign wr_fcr = reg_wr_i && reg_addr_i == `FSP_A_FCR;

  // Rate synthesis: the accumulator gains the multiplier each clock and
  // sheds the divisor on every base tick. The base must stay below clk_i.
  logic [32:0] acc_sum;
  logic [15:0] divv, dv_m1;
  logic        base_tk, os_tk;
  logic [4:0]  osn;
  logic [5:0]  blast, half_m1, sl_m1;
  logic        rate_wr;
  assign rate_wr = reg_wr_i && (reg_addr_i == `FSP_A_MUL
                                || reg_addr_i == `FSP_A_DIV);
  always_comb begin
    acc_sum = {1'b0, acc} + {1'b0, mult};
    base_tk = acc_sum >= {1'b0, ddiv};
    divv    = {divisor_high_byte, dll};
    dv_m1   = (divv == 16'h0) ? 16'h0 : divv - 16'h1;
    os_tk   = base_tk && dcnt >= dv_m1;
    osn     = os13 ? 5'd13 : 5'd16;
    blast   = {1'b0, osn} - 6'h1;
    half_m1 = {2'b0, osn[4:1]} - 6'h1;
    if (!lcr[`FSP_LCR_STB]) begin
      sl_m1 = blast;
    end else if (lcr[1:0] == 2'b00) begin
      sl_m1 = blast + {2'b0, osn[4:1]};
    end else begin
      sl_m1 = blast + {1'b0, osn};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc  <= 32'h0;
      dcnt <= 16'h0;
    end else begin
      if (base_tk) begin
        dcnt <= os_tk ? 16'h0 : dcnt + 16'h1;
      end
      // A new ratio restarts the phase. A remainder left by a ratio above
      // one would otherwise keep base ticks on for a very long time.
      if (rate_wr) begin
        acc  <= 32'h0;
      end else if (base_tk) begin
        acc  <= 32'(acc_sum - {1'b0, ddiv});
      end else begin
        acc  <= acc_sum[31:0];
      end
    end
  end

  // Pin synchronisers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_m  <= 1'b1;
      rx_s  <= 1'b1;
      cts_m <= 1'b1;
      cts_s <= 1'b1;
    end else begin
      rx_m  <= port1_serial_in_i;
      rx_s  <= rx_m;
      cts_m <= port1_cts_in_n_i;
      cts_s <= cts_m;
    end
  end

  // FIFOs. With the FIFOs disabled each side holds a single character.
  logic [7:0]    rx_mem [DEPTH];
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
  logic [AW:0]   rx_cnt, tx_cnt, lim;
  logic          rx_full, tx_full, rx_push, rx_pop, tx_push, tx_pop;
  logic          rx_clr, tx_clr, rx_done;
  logic [7:0]    rx_data;
  assign lim     = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign rx_full = rx_cnt >= lim;
  assign tx_full = tx_cnt >= lim;
  assign rx_push = rx_done && !rx_full;
  assign rx_pop  = rd_buf && rx_cnt != '0;
  assign tx_push = wr_buf && !tx_full;
  assign rx_clr  = wr_fcr && reg_wdata_i[`FSP_FCR_RXR];
  assign tx_clr  = wr_fcr && reg_wdata_i[`FSP_FCR_TXR];

  always_ff @(posedge clk_i) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_data;
    end
    if (tx_push) begin
      tx_mem[tx_wp] <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end else begin
      if (rx_clr) begin
        rx_wp  <= '0;
        rx_rp  <= '0;
        rx_cnt <= '0;
      end else begin
        rx_wp  <= rx_wp + AW'(rx_push);
        rx_rp  <= rx_rp + AW'(rx_pop);
        rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      end
      if (tx_clr) begin
        tx_wp  <= '0;
        tx_rp  <= '0;
        tx_cnt <= '0;
      end else begin
        tx_wp  <= tx_wp + AW'(tx_push);
        tx_rp  <= tx_rp + AW'(tx_pop);
        tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      end
    end
  end

  // Transmitter.
  fsp_tx_st_t tst, next_tst;
  logic [5:0] tos, next_tos;
  logic [2:0] tbit, next_tbit;
  logic [7:0] tsh, next_tsh;
  logic       tpar, next_tpar, next_txd, cts_ok, tend;
  assign cts_ok = !modem_control_register[`FSP_MCR_AFE] || !cts_s;
  always_comb begin
    next_tst  = tst;
    next_tos  = tos;
    next_tbit = tbit;
    next_tsh  = tsh;
    next_tpar = tpar;
    tx_pop    = 1'b0;
    tend      = os_tk && tos == ((tst == T_STOP) ? sl_m1 : blast);
    if (os_tk) begin
      next_tos = tend ? 6'h0 : tos + 6'h1;
    end
    case (tst)
      T_IDLE: begin
        next_tos = 6'h0;
        // A byte in flight is never stopped; only the launch looks at CTS.
        if (tx_cnt != '0 && cts_ok && !tx_clr) begin
          tx_pop    = 1'b1;
          next_tsh  = tx_mem[tx_rp];
          next_tpar = ^(tx_mem[tx_rp] & fsp_mask(lcr[1:0]))
                      ^ !lcr[`FSP_LCR_EPS];
          next_tst  = T_START;
        end
      end
      T_START: begin
        if (tend) begin
          next_tbit = 3'h0;
          next_tst  = T_DATA;
        end
      end
      T_DATA: begin
        if (tend) begin
          next_tsh  = tsh >> 1;
          next_tbit = tbit + 3'h1;
          if (tbit == {1'b1, lcr[1:0]}) begin
            next_tst = lcr[`FSP_LCR_PEN] ? T_PAR : T_STOP;
          end
        end
      end
      T_PAR: begin
        if (tend) begin
          next_tst = T_STOP;
        end
      end
      T_STOP: begin
        if (tend) begin
          next_tst = T_IDLE;
        end
      end
      default: next_tst = T_IDLE;
    endcase
    case (next_tst)
      T_START: next_txd = 1'b0;
      T_DATA:  next_txd = next_tsh[0];
      T_PAR:   next_txd = next_tpar;
      default: next_txd = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tst                <= T_IDLE;
      tos                <= 6'h0;
      tbit               <= 3'h0;
      tsh                <= 8'h0;
      tpar               <= 1'b0;
      port1_serial_out_o <= 1'b1;
    end else begin
      tst                <= next_tst;
      tos                <= next_tos;
      tbit               <= next_tbit;
      tsh                <= next_tsh;
      tpar               <= next_tpar;
      port1_serial_out_o <= next_txd;
    end
  end

  // Receiver: start is checked at mid bit, then every bit at its middle.
  fsp_rx_st_t rst_q, next_rst;
  logic [5:0] ros, next_ros;
  logic [2:0] rbit, next_rbit;
  logic [7:0] rsh, next_rsh;
  logic       rpar, next_rpar, rend, pe_ev, fe_ev;
  assign rx_data = rsh >> (2'd3 - lcr[1:0]);
  always_comb begin
    next_rst  = rst_q;
    next_ros  = ros;
    next_rbit = rbit;
    next_rsh  = rsh;
    next_rpar = rpar;
    rx_done   = 1'b0;
    pe_ev     = 1'b0;
    fe_ev     = 1'b0;
    rend      = os_tk && ros == ((rst_q == R_START) ? half_m1 : blast);
    if (os_tk) begin
      next_ros = rend ? 6'h0 : ros + 6'h1;
    end
    case (rst_q)
      R_IDLE: begin
        next_ros = 6'h0;
        if (!rx_s) begin
          next_rst = R_START;
        end
      end
      R_START: begin
        if (rend) begin
          next_rbit = 3'h0;
          next_rst  = rx_s ? R_IDLE : R_DATA;
        end
      end
      R_DATA: begin
        if (rend) begin
          next_rsh  = {rx_s, rsh[7:1]};
          next_rbit = rbit + 3'h1;
          if (rbit == {1'b1, lcr[1:0]}) begin
            next_rst = lcr[`FSP_LCR_PEN] ? R_PAR : R_STOP;
          end
        end
      end
      R_PAR: begin
        if (rend) begin
          next_rpar = rx_s;
          next_rst  = R_STOP;
        end
      end
      R_STOP: begin
        if (rend) begin
          rx_done  = 1'b1;
          fe_ev    = !rx_s;
          pe_ev    = lcr[`FSP_LCR_PEN] && (rpar != (^(rx_data
                     & fsp_mask(lcr[1:0])) ^ !lcr[`FSP_LCR_EPS]));
          next_rst = R_IDLE;
        end
      end
      default: next_rst = R_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= R_IDLE;
      ros   <= 6'h0;
      rbit  <= 3'h0;
      rsh   <= 8'h0;
      rpar  <= 1'b0;
    end else begin
      rst_q <= next_rst;
      ros   <= next_ros;
      rbit  <= next_rbit;
      rsh   <= next_rsh;
      rpar  <= next_rpar;
    end
  end

  // Trailing bytes: a quiet receive FIFO below trigger still asks for DMA.
  logic [9:0] trc, next_trc, trail_lim;
  logic       trail;
  assign trail_lim = 10'(`FSP_TRAIL_BITS) * {5'h0, osn};
  assign trail     = trc >= trail_lim;
  always_comb begin
    next_trc = trc;
    if (rx_push || rx_pop || rx_cnt == '0) begin
      next_trc = 10'h0;
    end else if (os_tk && !trail) begin
      next_trc = trc + 10'h1;
    end
  end

  // Registered outputs and status flags. Set wins over the clear on read.
  logic        full_auto, dr, thre, temt;
  logic        next_rts, next_drx, next_dtx, next_oe, next_pe, next_fe;
  logic [31:0] next_rdata;
  assign full_auto = modem_control_register[`FSP_MCR_AFE] && modem_control_register[`FSP_MCR_RTS];
  assign dr        = rx_cnt != '0;
  assign thre      = tx_cnt == '0;
  assign temt      = thre && tst == T_IDLE;
  always_comb begin
    // The remote may still land one byte after release; room above the
    // threshold absorbs it.
    next_rts = full_auto ? (rx_cnt >= thr)
                         : !modem_control_register[`FSP_MCR_RTS];
    next_drx = dma[`FSP_DMA_ACT] && dma[`FSP_DMA_DIR] && dr
               && (rx_cnt >= thr || trail);
    next_dtx = dma[`FSP_DMA_ACT] && !dma[`FSP_DMA_DIR]
               && !tx_full;
    next_oe  = (oe && !rd_lsr) || (rx_done && rx_full);
    next_pe  = (pe && !rd_lsr) || (rx_push && pe_ev);
    next_fe  = (fe && !rd_lsr) || (rx_push && fe_ev);
    next_rdata = 32'h0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `FSP_A_BUF: next_rdata = {24'h0, divisor_latch_access ? dll
                                 : (dr ? rx_mem[rx_rp] : 8'h0)};
        `FSP_A_IER: next_rdata = {24'h0, divisor_latch_access ? divisor_high_byte : ier};
        `FSP_A_FCR: next_rdata = {31'h0, fifo_en};
        `FSP_A_LCR: next_rdata = {24'h0, lcr};
        `FSP_A_MCR: next_rdata = {24'h0, modem_control_register};
        // Error flags read as they stand; the read clears them after.
        `FSP_A_LSR: next_rdata = {25'h0, temt, thre, 1'b0,
                                  fe, pe, oe, dr};
        `FSP_A_THR: next_rdata = 32'(thr);
        `FSP_A_RXO: next_rdata = 32'(rx_cnt);
        `FSP_A_TXO: next_rdata = 32'(tx_cnt);
        `FSP_A_MUL: next_rdata = mult;
        `FSP_A_DIV: next_rdata = ddiv;
        `FSP_A_DMA: next_rdata = {30'h0, dma};
        `FSP_A_OSC: next_rdata = {31'h0, os13};
        default:    next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dll               <= `FSP_RST_DLL;
      divisor_high_byte               <= 8'h0;
      ier               <= 8'h0;
      lcr               <= `FSP_RST_LCR;
      modem_control_register               <= 8'h0;
      fifo_en           <= 1'b1;
      os13              <= 1'b0;
      thr               <= `FSP_RST_THR;
      mult              <= `FSP_RST_MUL;
      ddiv              <= `FSP_RST_DIV;
      dma               <= 2'h0;
      oe                <= 1'b0;
      pe                <= 1'b0;
      fe                <= 1'b0;
      trc               <= 10'h0;
      reg_rdata_o       <= 32'h0;
      port1_rts_out_n_o <= 1'b1;
      dma_rx_req_o      <= 1'b0;
      dma_tx_req_o      <= 1'b0;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `FSP_A_BUF: if (divisor_latch_access) dll <= reg_wdata_i[7:0];
          // Zero enables leave the port polled; no interrupt logic here.
          `FSP_A_IER: if (divisor_latch_access) divisor_high_byte <= reg_wdata_i[7:0];
                      else ier <= reg_wdata_i[7:0];
          `FSP_A_FCR: fifo_en <= reg_wdata_i[`FSP_FCR_EN];
          `FSP_A_LCR: lcr <= reg_wdata_i[7:0];
          `FSP_A_MCR: modem_control_register <= reg_wdata_i[7:0];
          `FSP_A_THR: thr <= reg_wdata_i[AW:0];
          `FSP_A_MUL: mult <= reg_wdata_i;
          `FSP_A_DIV: ddiv <= reg_wdata_i;
          `FSP_A_DMA: dma <= reg_wdata_i[1:0];
          `FSP_A_OSC: os13 <= reg_wdata_i[0];
          default: ;
        endcase
      end
      oe                <= next_oe;
      pe                <= next_pe;
      fe                <= next_fe;
      trc               <= next_trc;
      reg_rdata_o       <= next_rdata;
      port1_rts_out_n_o <= next_rts;
      dma_rx_req_o      <= next_drx;
      dma_tx_req_o      <= next_dtx;
    end
  end

  // Checks.
  sequence s_launch;
    (tst == T_IDLE) ##1 (tst == T_START);
  endsequence
  sequence s_lsr_read;
    reg_rd_i && reg_addr_i == `FSP_A_LSR;
  endsequence

  a_start_low: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_launch |-> !port1_serial_out_o && $past(port1_serial_out_o))
    else $error("Start bit did not fall from idle high.");
  a_stop_high: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (tst == T_STOP || tst == T_IDLE) |-> port1_serial_out_o)
    else $error("Line not high during stop or idle.");
  a_cts_gate: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_launch |-> $past(!modem_control_register[`FSP_MCR_AFE] || !cts_s))
    else $error("Byte launched while clear-to-send was high.");
  a_rts_level: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    full_auto |=> port1_rts_out_n_o == ($past(rx_cnt) >= $past(thr)))
    else $error("Request-to-send does not follow the threshold.");
  a_ready_flag: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_lsr_read |=> reg_rdata_o[0] == ($past(rx_cnt) != '0))
    else $error("Data ready flag disagrees with receive level.");
  a_overrun_set: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rx_done && rx_full && !rx_clr) |=> oe && rx_cnt == $past(rx_cnt)
                                        - (AW+1)'($past(rx_pop)))
    else $error("Overrun not flagged or character not dropped.");
  a_fifo_bound: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (tx_full && wr_buf && !tx_pop && !tx_clr) |=> tx_cnt == $past(tx_cnt))
    else $error("Write into full transmit FIFO changed its level.");
  a_div_word: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (base_tk && {divisor_high_byte, dll} != 16'h0 && dcnt == {divisor_high_byte, dll} - 16'h1)
    |-> os_tk ##1 dcnt == 16'h0)
    else $error("Oversample tick not at the composed divisor.");
  a_trail_dma: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (trail && dr && dma == 2'b11) |=> dma_rx_req_o)
    else $error("Trailing receive bytes not requested for DMA.");
endmodule

//--- sim/fsp_remote.sv
// Remote serial device model: frame capture and a sender that obeys rts.
module fsp_remote (
  input  wire logic clk_i,
  input  wire logic ser_i,
  input  wire logic rts_n_i,
  output logic      ser_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int          bitclk = 32;
  int          nbits = 8;
  int          pen = 0;
  int          lost = 0;
  logic [10:0] q[$];
  logic [10:0] w;
  initial ser_o = 1'b1;
  // Sampling mid-bit tolerates a start bit that is one tick longer.
  always begin
    @(negedge ser_i);
    repeat (bitclk / 2) @(posedge clk_i);
    w = '0;
    for (int i = 0; i <= nbits + pen; i++) begin
      repeat (bitclk) @(posedge clk_i);
      w[i] = ser_i;
    end
    q.push_back(w);
  end
  task automatic send(input logic [7:0] b);
    for (int k = 0; k < 5000 && rts_n_i !== 1'b0; k++) begin
      @(posedge clk_i);
    end
    if (rts_n_i === 1'b0) begin
      for (int i = 0; i < 10; i++) begin
        ser_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
        repeat (bitclk) @(posedge clk_i);
      end
    end else begin
      // A byte held back for good is counted so the bench can fail on it.
      lost++;
    end
  endtask
endmodule

//--- sim/tb_fsp_uart.sv
// Self-checking bench for the fast serial port.
`include "fsp_cfg.svh"
module tb_fsp_uart;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        cts_n = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        ser_in, ser_out, rts_n, dma_rx, dma_tx;
  logic [31:0] d;
  logic [7:0]  b;
  logic [7:0]  lcr_tab[4] = '{8'h03, 8'h00, 8'h1a, 8'h0f};
  logic [10:0] exq[$];
  logic [7:0]  rxq[$];
  int          bad_count = 0;
  int          comparisons = 0;

  always #12.5 clk_i = ~clk_i;

  fsp_uart uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .port1_serial_in_i(ser_in),
    .port1_cts_in_n_i(cts_n), .port1_serial_out_o(ser_out),
    .port1_rts_out_n_o(rts_n), .dma_rx_req_o(dma_rx), .dma_tx_req_o(dma_tx));
  fsp_remote p (.clk_i(clk_i), .ser_i(ser_out), .rts_n_i(rts_n),
    .ser_o(ser_in));

  task automatic complete_run();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // The model keeps the expected line image: data, parity, first stop bit.
  task automatic tx_byte(input logic [7:0] v, input logic [7:0] lcr);
    int   n;
    logic pb;
    n = 5 + lcr[1:0];
    v = v & ((8'h1 << n) - 8'h1);
    pb = lcr[4] ? ^v : ~^v;
    exq.push_back(11'(v) | (lcr[3] ? 11'(pb) << n : 11'h0)
                  | (11'h1 << (n + lcr[3])));
    wr(`FSP_A_BUF, 32'(v));
  endtask
  task automatic check_tx(input int n);
    int k;
    for (k = 0; k < 20000 && p.q.size() < n; k++) @(posedge clk_i);
    if (p.q.size() < n) begin
      bad_count++;
      $display("ERROR tx_wait expected %0d seen %0d", n, p.q.size());
      complete_run();
    end
    while (exq.size() > 0) chk("tx_frame", 32'(exq.pop_front()),
                               32'(p.q.pop_front()));
  endtask
  task automatic check_rx(input int n);
    repeat (n) begin
      rd(`FSP_A_BUF, d);
      chk("rx_byte", 32'(rxq.pop_front()), d);
    end
  endtask

  initial begin
    void'($urandom(32'h488d));
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`FSP_A_IER, d);
    chk("ier_reset", 32'h0, d);
    rd(`FSP_A_FCR, d);
    chk("fifo_on", 32'h1, d & 32'h1);
    rd(4'hd, d);
    chk("unmapped", 32'h0, d);
    // A fast base keeps each bit at 32 clocks so the run stays short.
    wr(`FSP_A_MUL, 32'h1);
    wr(`FSP_A_DIV, 32'h2);
    wr(`FSP_A_LCR, 32'h83);
    wr(`FSP_A_BUF, 32'h1);
    wr(`FSP_A_IER, 32'h0);
    rd(`FSP_A_BUF, d);
    chk("div_low", 32'h1, d);
    wr(`FSP_A_MCR, 32'h2);
    foreach (lcr_tab[i]) begin
      wr(`FSP_A_LCR, 32'(lcr_tab[i]));
      p.nbits = 5 + lcr_tab[i][1:0];
      p.pen = lcr_tab[i][3];
      repeat (2) tx_byte(8'($urandom), lcr_tab[i]);
      check_tx(2);
      settle(96);
      rd(`FSP_A_LSR, d);
      chk("tx_idle", 32'h60, d & 32'h60);
    end
    wr(`FSP_A_LCR, 32'h3);
    p.nbits = 8;
    p.pen = 0;
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      rxq.push_back(b);
      p.send(b);
    end
    rd(`FSP_A_LSR, d);
    chk("data_ready", 32'h1, d & 32'h1);
    check_rx(3);
    rd(`FSP_A_LSR, d);
    chk("data_ready", 32'h0, d & 32'h1);
    wr(`FSP_A_THR, 32'h2);
    wr(`FSP_A_MCR, 32'h22);
    wr(`FSP_A_DMA, 32'h3);
    settle(3);
    chk("rts_n", 32'h0, 32'(rts_n));
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      rxq.push_back(b);
      p.send(b);
    end
    settle(4);
    chk("rts_n", 32'h1, 32'(rts_n));
    chk("dma_rx", 32'h1, 32'(dma_rx));
    check_rx(1);
    settle(4);
    chk("rts_n", 32'h0, 32'(rts_n));
    chk("dma_rx", 32'h0, 32'(dma_rx));
    settle(1400);
    chk("dma_rx", 32'h1, 32'(dma_rx));
    check_rx(1);
    wr(`FSP_A_DMA, 32'h1);
    settle(3);
    chk("dma_tx", 32'h1, 32'(dma_tx));
    wr(`FSP_A_MCR, 32'h20);
    cts_n <= 1'b1;
    // With clear-to-send held off, overfill the transmit FIFO, then flush.
    for (int i = 0; i < 65; i++) begin
      wr(`FSP_A_BUF, 32'(i));
    end
    rd(`FSP_A_TXO, d);
    chk("tx_level", 32'd64, d);
    chk("dma_tx", 32'h0, 32'(dma_tx));
    wr(`FSP_A_FCR, 32'h5);
    rd(`FSP_A_TXO, d);
    chk("tx_level", 32'h0, d);
    tx_byte(8'h5a, 8'h03);
    settle(200);
    chk("held_line", 32'h1, 32'(ser_out));
    chk("rts_n", 32'h1, 32'(rts_n));
    @(posedge clk_i);
    cts_n <= 1'b0;
    check_tx(1);
    wr(`FSP_A_MCR, 32'h2);
    wr(`FSP_A_OSC, 32'h1);
    p.bitclk = 26;
    tx_byte(8'($urandom), 8'h03);
    check_tx(1);
    repeat (65) p.send(8'($urandom));
    rd(`FSP_A_RXO, d);
    chk("rx_level", 32'd64, d);
    rd(`FSP_A_LSR, d);
    chk("overrun", 32'h2, d & 32'h2);
    chk("rts_wait", 32'h0, 32'(p.lost));
    complete_run();
  end
endmodule
